// ### shared/ctl_bank_pkg.sv
// Constants for the peripheral control nibble bank.
// Assumes a single system clock and reset shared by all users.
package ctl_bank_pkg;

  // Space geometry
  localparam int          NUM_LOC  = 64;
  localparam int          NIB_W    = 4;
  localparam int          ADDR_W   = 6;
  localparam int          ROW_W    = 2;
  localparam int          COL_W    = 4;
  localparam logic [3:0]  NIB_RST  = 4'h0;
  localparam logic [3:0]  NIB_NONE = 4'h0;
  localparam logic [3:0]  NIB_ALL  = 4'hF;

  // Location addresses, row * 16 + column
  localparam logic [5:0]  ADDR_STACK_PTR  = 6'h01;
  localparam logic [5:0]  ADDR_WDT_CLK    = 6'h02;
  localparam logic [5:0]  ADDR_WDT_CLR    = 6'h03;
  localparam logic [5:0]  ADDR_BUF_SP     = 6'h04;
  localparam logic [5:0]  ADDR_SF_RST     = 6'h05;
  localparam logic [5:0]  ADDR_CE_CNT     = 6'h06;
  localparam logic [5:0]  ADDR_MOVT_SEL   = 6'h07;
  localparam logic [5:0]  ADDR_SYN_MODE   = 6'h10;
  localparam logic [5:0]  ADDR_SYN_REF    = 6'h11;
  localparam logic [5:0]  ADDR_SYN_UNLK   = 6'h12;
  localparam logic [5:0]  ADDR_TONE_PIN   = 6'h13;
  localparam logic [5:0]  ADDR_TONE_CLK   = 6'h14;
  localparam logic [5:0]  ADDR_WDT_STAT   = 6'h16;
  localparam logic [5:0]  ADDR_BT_CARRY   = 6'h17;
  localparam logic [5:0]  ADDR_FG_CH      = 6'h20;
  localparam logic [5:0]  ADDR_IF_GATE    = 6'h21;
  localparam logic [5:0]  ADDR_IF_MODE    = 6'h22;
  localparam logic [5:0]  ADDR_IF_CTRL    = 6'h23;
  localparam logic [5:0]  ADDR_ADC_CH     = 6'h24;
  localparam logic [5:0]  ADDR_ADC_MODE   = 6'h25;
  localparam logic [5:0]  ADDR_PWM_CLK    = 6'h26;
  localparam logic [5:0]  ADDR_PWM_PIN    = 6'h27;

  // Field positions
  localparam int          FLAG_BIT     = 0;
  localparam int          WDT_CLR_BIT  = 3;
  localparam int          IF_START_BIT = 1;
  localparam int          IF_RESET_BIT = 0;
  localparam int          ADC_CMP_BIT  = 0;

  // Per-location attribute: writable, readable, live status,
  // read-and-reset and write-pulse bit masks
  typedef struct packed {
    logic [3:0] wr;
    logic [3:0] rd;
    logic [3:0] hw;
    logic [3:0] rc;
    logic [3:0] pulse;
  } loc_attr_s;

  function automatic loc_attr_s loc_attr(input logic [5:0] a);
    loc_attr_s r;
    r = '{NIB_NONE, NIB_NONE, NIB_NONE, NIB_NONE, NIB_NONE};
    case (a)
      ADDR_STACK_PTR, ADDR_CE_CNT, ADDR_SYN_MODE, ADDR_SYN_REF,
      ADDR_TONE_CLK, ADDR_FG_CH, ADDR_IF_MODE: begin
        r.wr = NIB_ALL;
        r.rd = NIB_ALL;
      end
      ADDR_WDT_CLK, ADDR_SF_RST, ADDR_MOVT_SEL, ADDR_TONE_PIN,
      ADDR_PWM_PIN: begin
        r.wr = 4'h3;
        r.rd = 4'h3;
      end
      ADDR_ADC_CH: begin
        r.wr = 4'h7;
        r.rd = 4'h7;
      end
      ADDR_PWM_CLK: begin
        r.wr = 4'h1;
        r.rd = 4'h1;
      end
      ADDR_ADC_MODE: begin
        r.wr = 4'h6;
        r.rd = 4'h7;
        r.hw = 4'h1;
      end
      ADDR_BUF_SP: begin
        r.rd = 4'h3;
        r.hw = 4'h3;
      end
      ADDR_IF_GATE: begin
        r.rd = 4'h1;
        r.hw = 4'h1;
      end
      ADDR_SYN_UNLK, ADDR_WDT_STAT, ADDR_BT_CARRY: begin
        r.rd = 4'h1;
        r.rc = 4'h1;
      end
      ADDR_WDT_CLR: r.pulse = 4'h8;
      ADDR_IF_CTRL: r.pulse = 4'h3;
      default: r.wr = NIB_NONE;
    endcase
    return r;
  endfunction : loc_attr

endpackage : ctl_bank_pkg

// ### rtl/ctl_loc_decode.sv
// Address decoder for the 64-nibble control space.
// Assumes read and write strobes come from logic on the same clock.
module ctl_loc_decode
  import ctl_bank_pkg::*;
(
  // Access request
  input  wire logic [ADDR_W-1:0]  i_addr,
  input  wire logic               i_rd,
  input  wire logic               i_wr,
  // One-hot selects
  output logic      [NUM_LOC-1:0] o_rd_sel,
  output logic      [NUM_LOC-1:0] o_wr_sel
);

  logic [ROW_W-1:0] row;
  logic [COL_W-1:0] col;

  assign row = i_addr[ADDR_W-1:COL_W];
  assign col = i_addr[COL_W-1:0];

  // Read wins; a write in the same cycle is dropped
  genvar g;
  generate
    for (g = 0; g < NUM_LOC; g++) begin : g_sel
      assign o_rd_sel[g] = i_rd &&
        ({row, col} == ADDR_W'(g));
      assign o_wr_sel[g] = i_wr && !i_rd &&
        ({row, col} == ADDR_W'(g));
    end
  endgenerate

endmodule : ctl_loc_decode

// ### rtl/ctl_nibble_bank.sv
// Peripheral control nibble bank: 64 four-bit control locations.
// Assumes peripheral status and event inputs are on i_mclk.
// How it works
// - 64 nibbles at control addresses 00 to 3F
// - Each location has one access attribute, except 25, which mixes writable and status bits
// - Read-and-reset returns contents then clears flag
// - Writes to read-only locations change nothing
// - Write-only locations read back as zero
// - Fixed-zero bits always read as zero
// - Unused locations read as zero, ignore writes
// - Access only through window register transfers
module ctl_nibble_bank
  import ctl_bank_pkg::*;
(
  // Clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_arst_n,
  // Window register transfer port
  input  wire logic [ADDR_W-1:0] i_rf_addr,
  input  wire logic              i_regfile_read_instr,
  input  wire logic              i_regfile_write_instr,
  input  wire logic [NIB_W-1:0]  i_window_wdata,
  output logic      [NIB_W-1:0]  o_window_rdata,
  output logic                   o_window_rvalid,
  // Live status from peripherals
  input  wire logic [1:0]        i_buffer_stack_pointer,
  input  wire logic              i_if_count_gate_open,
  input  wire logic              i_adc_compare,
  // Flag events from peripherals
  input  wire logic              i_synth_unlock_event,
  input  wire logic              i_watchdog_stack_event,
  input  wire logic              i_base_timer_carry_event,
  // System settings
  output logic      [3:0]        o_stack_pointer,
  output logic      [1:0]        o_watchdog_clock_select,
  output logic      [1:0]        o_stack_fault_reset_select,
  output logic      [3:0]        o_chip_enable_reset_counter,
  output logic      [1:0]        o_table_move_bit_select,
  // Synthesizer and tone settings
  output logic      [3:0]        o_synth_mode_select,
  output logic      [3:0]        o_synth_reference_select,
  output logic      [1:0]        o_tone_pin_function_select,
  output logic      [3:0]        o_tone_clock_select,
  // Counter, converter and pulse width settings
  output logic      [3:0]        o_freq_gate_channel,
  output logic      [3:0]        o_if_count_mode,
  output logic      [2:0]        o_analog_sample_channel,
  output logic      [1:0]        o_analog_sample_mode,
  output logic                   o_pulse_width_clock_select,
  output logic      [1:0]        o_pulse_width_pin_select,
  // Flags as currently held
  output logic                   o_synth_unlock_flag,
  output logic                   o_watchdog_stack_flag,
  output logic                   o_base_timer_carry_flag,
  // Write-only command pulses
  output logic                   o_watchdog_counter_clear,
  output logic                   o_if_count_start,
  output logic                   o_if_count_reset
);

  // Whole module state
  typedef struct packed {
    logic [NUM_LOC-1:0][NIB_W-1:0] nib;
    logic [NIB_W-1:0]              rdata;
    logic                          rvalid;
    logic                          wdt_clr;
    logic                          if_start;
    logic                          if_reset;
  } bank_state_s;

  bank_state_s st_reg;
  bank_state_s st_next;

  logic [NUM_LOC-1:0]            rd_sel;
  logic [NUM_LOC-1:0]            wr_sel;
  logic [NUM_LOC-1:0][NIB_W-1:0] hw_val;
  logic [NUM_LOC-1:0][NIB_W-1:0] hw_set;
  logic [NUM_LOC-1:0][NIB_W-1:0] nib_upd;
  logic [NUM_LOC-1:0][NIB_W-1:0] rd_val;
  logic [NIB_W-1:0]              rd_raw;
  logic                          wr_hit_wdt;
  logic                          wr_hit_ifc;

  // Location select; the only path from the window port to the nibbles
  ctl_loc_decode u_decode (
    .i_addr   (i_rf_addr),
    .i_rd     (i_regfile_read_instr),
    .i_wr     (i_regfile_write_instr),
    .o_rd_sel (rd_sel),
    .o_wr_sel (wr_sel)
  );

  // Live status bits placed at their locations
  always_comb begin
    hw_val = '0;
    hw_val[ADDR_BUF_SP][1:0] = i_buffer_stack_pointer;
    hw_val[ADDR_IF_GATE][FLAG_BIT] = i_if_count_gate_open;
    hw_val[ADDR_ADC_MODE][ADC_CMP_BIT] = i_adc_compare;
  end

  // Flag events placed at their locations
  always_comb begin
    hw_set = '0;
    hw_set[ADDR_SYN_UNLK][FLAG_BIT] = i_synth_unlock_event;
    hw_set[ADDR_WDT_STAT][FLAG_BIT] = i_watchdog_stack_event;
    hw_set[ADDR_BT_CARRY][FLAG_BIT] = i_base_timer_carry_event;
  end

  // Write-only command locations hit by a write
  assign wr_hit_wdt = wr_sel[ADDR_WDT_CLR];
  assign wr_hit_ifc = wr_sel[ADDR_IF_CTRL];

  // Per-location update and read value, one copy for every nibble
  genvar g;
  generate
    for (g = 0; g < NUM_LOC; g++) begin : g_loc
      loc_attr_s        la;
      logic [NIB_W-1:0] held;
      logic [NIB_W-1:0] keep_m;
      logic [NIB_W-1:0] after_wr;
      logic [NIB_W-1:0] after_rd;
      logic [NIB_W-1:0] after_hw;
      logic [NIB_W-1:0] after_set;
      logic [NIB_W-1:0] live;

      assign la = loc_attr(ADDR_W'(g));
      assign held = st_reg.nib[g];
      assign keep_m = la.wr | la.hw | la.rc;

      // Only writable bits take the window data
      always_comb begin
        after_wr = held;
        if (wr_sel[g]) begin
          after_wr = (i_window_wdata & la.wr) | (held & ~la.wr);
        end
      end

      // Read clears the flag it returned
      always_comb begin
        after_rd = after_wr;
        if (rd_sel[g]) begin
          after_rd = after_wr & ~la.rc;
        end
      end

      // Status bits follow the peripheral
      assign after_hw = (after_rd & ~la.hw) | (hw_val[g] & la.hw);
      // Event in the clearing cycle wins, so no event is lost
      assign after_set = after_hw | (hw_set[g] & la.rc);
      // Bits with no function never hold a one
      assign nib_upd[g] = after_set & keep_m;

      // Status bits taken live so the answer is current
      assign live = (held & ~la.hw) | (hw_val[g] & la.hw);
      // Write-only, unused and fixed-zero bits read as zero
      assign rd_val[g] = live & la.rd;
    end
  endgenerate

  // Next state
  always_comb begin
    st_next = st_reg;
    st_next.nib = nib_upd;
    st_next.rvalid = 1'b0;
    st_next.wdt_clr = 1'b0;
    st_next.if_start = 1'b0;
    st_next.if_reset = 1'b0;
    // Read answer one cycle after the request
    if (i_regfile_read_instr) begin
      st_next.rdata = rd_raw;
      st_next.rvalid = 1'b1;
    end
    // Command pulses; bits stay unstored
    if (wr_hit_wdt) begin
      st_next.wdt_clr = i_window_wdata[WDT_CLR_BIT];
    end
    if (wr_hit_ifc) begin
      st_next.if_start = i_window_wdata[IF_START_BIT];
      st_next.if_reset = i_window_wdata[IF_RESET_BIT];
    end
  end

  // Read mux
  assign rd_raw = rd_val[i_rf_addr];

  // State register
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Window read answer
  assign o_window_rdata = st_reg.rdata;
  assign o_window_rvalid = st_reg.rvalid;

  // System settings
  assign o_stack_pointer = st_reg.nib[ADDR_STACK_PTR];
  assign o_watchdog_clock_select = st_reg.nib[ADDR_WDT_CLK][1:0];
  assign o_stack_fault_reset_select = st_reg.nib[ADDR_SF_RST][1:0];
  assign o_chip_enable_reset_counter = st_reg.nib[ADDR_CE_CNT];
  assign o_table_move_bit_select = st_reg.nib[ADDR_MOVT_SEL][1:0];

  // Synthesizer and tone settings
  assign o_synth_mode_select = st_reg.nib[ADDR_SYN_MODE];
  assign o_synth_reference_select = st_reg.nib[ADDR_SYN_REF];
  assign o_tone_pin_function_select = st_reg.nib[ADDR_TONE_PIN][1:0];
  assign o_tone_clock_select = st_reg.nib[ADDR_TONE_CLK];

  // Counter, converter and pulse width settings
  assign o_freq_gate_channel = st_reg.nib[ADDR_FG_CH];
  assign o_if_count_mode = st_reg.nib[ADDR_IF_MODE];
  assign o_analog_sample_channel = st_reg.nib[ADDR_ADC_CH][2:0];
  assign o_analog_sample_mode = st_reg.nib[ADDR_ADC_MODE][2:1];
  assign o_pulse_width_clock_select = st_reg.nib[ADDR_PWM_CLK][0];
  assign o_pulse_width_pin_select = st_reg.nib[ADDR_PWM_PIN][1:0];

  // Flags
  assign o_synth_unlock_flag = st_reg.nib[ADDR_SYN_UNLK][FLAG_BIT];
  assign o_watchdog_stack_flag = st_reg.nib[ADDR_WDT_STAT][FLAG_BIT];
  assign o_base_timer_carry_flag = st_reg.nib[ADDR_BT_CARRY][FLAG_BIT];

  // Command pulses, one cycle wide
  assign o_watchdog_counter_clear = st_reg.wdt_clr;
  assign o_if_count_start = st_reg.if_start;
  assign o_if_count_reset = st_reg.if_reset;

endmodule : ctl_nibble_bank

// ### bench/ctl_nibble_bank_assertions.sv
// Window port, flag and command pulse checks for the nibble bank.
// Assumes binding into ctl_nibble_bank; sees its ports only.
module ctl_nibble_bank_assertions
  import ctl_bank_pkg::*;
(
  input wire logic              i_mclk,
  input wire logic              i_arst_n,
  input wire logic [ADDR_W-1:0] i_rf_addr,
  input wire logic              i_regfile_read_instr,
  input wire logic              i_regfile_write_instr,
  input wire logic [NIB_W-1:0]  i_window_wdata,
  input wire logic [NIB_W-1:0]  o_window_rdata,
  input wire logic              o_window_rvalid,
  input wire logic              i_synth_unlock_event,
  input wire logic              i_base_timer_carry_event,
  input wire logic              o_synth_unlock_flag,
  input wire logic              o_base_timer_carry_flag,
  input wire logic [1:0]        o_analog_sample_mode,
  input wire logic [3:0]        o_if_count_mode,
  input wire logic              o_watchdog_counter_clear
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] wd_reg;
  logic       wr_ok;
  logic       rd;
  // Write data of the previous edge, to compare stored settings
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wd_reg <= NIB_RST;
    end else begin
      wd_reg <= i_window_wdata;
    end
  end
  // A write with the read strobe high is dropped
  assign wr_ok = i_regfile_write_instr && !i_regfile_read_instr;
  assign rd = i_regfile_read_instr;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  a_read_answer: assert property (rd |=> o_window_rvalid)
    else $error("read answer missing");
  a_valid_only_read: assert property (!rd |=> !o_window_rvalid)
    else $error("stray read valid");
  a_flag_read_value: assert property (rd && i_rf_addr == ADDR_SYN_UNLK
    |=> o_window_rdata == {3'h0, $past(o_synth_unlock_flag)})
    else $error("flag read value wrong");
  a_flag_read_clear: assert property (rd && i_rf_addr == ADDR_SYN_UNLK
    && !i_synth_unlock_event |=> !o_synth_unlock_flag)
    else $error("flag not cleared by read");
  a_flag_write_kept: assert property (wr_ok && i_rf_addr == ADDR_BT_CARRY
    && !i_base_timer_carry_event |=> $stable(o_base_timer_carry_flag))
    else $error("flag changed by write");
  a_fixed_zero_bit: assert property (rd && i_rf_addr == ADDR_ADC_CH
    |=> !o_window_rdata[3])
    else $error("fixed zero bit read as one");
  a_mixed_write: assert property (wr_ok && i_rf_addr == ADDR_ADC_MODE
    |=> o_analog_sample_mode == wd_reg[2:1])
    else $error("converter mode not stored");
  a_rw_write: assert property (wr_ok && i_rf_addr == ADDR_IF_MODE
    |=> o_if_count_mode == wd_reg)
    else $error("counter mode not stored");
  a_clear_pulse_on: assert property (wr_ok && i_rf_addr == ADDR_WDT_CLR
    && i_window_wdata[WDT_CLR_BIT] |=> o_watchdog_counter_clear)
    else $error("clear pulse missing");
  a_clear_pulse_off: assert property (!(wr_ok && i_rf_addr == ADDR_WDT_CLR)
    |=> !o_watchdog_counter_clear)
    else $error("stray clear pulse");
  a_unused_quiet: assert property (wr_ok && i_rf_addr == 6'h15
    |=> $stable(o_if_count_mode) && $stable(o_analog_sample_mode))
    else $error("unused write changed a setting");
endmodule : ctl_nibble_bank_assertions

bind ctl_nibble_bank ctl_nibble_bank_assertions chk_u (
  .i_mclk, .i_arst_n, .i_rf_addr, .i_regfile_read_instr,
  .i_regfile_write_instr, .i_window_wdata, .o_window_rdata,
  .o_window_rvalid, .i_synth_unlock_event, .i_base_timer_carry_event,
  .o_synth_unlock_flag, .o_base_timer_carry_flag, .o_analog_sample_mode,
  .o_if_count_mode, .o_watchdog_counter_clear
);

// ### bench/test_peripheral_control_nibble_bank.sv
// Self-checking bench for the control nibble bank.
// Assumes the bank alone, driven through its window port.
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  n_fail++; $display("Error %s expected %h seen %h", nm, e, g); end end
module test_peripheral_control_nibble_bank
  import ctl_bank_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk, rst_n, rd, wr, rvld, gate, cmp, wclr, ifs, ifr;
  logic [5:0] addr;
  logic [3:0] wdat, rdat, spo, ifm, d;
  logic [1:0] bsp, amode;
  logic [2:0] ev, flg;
  wire  [33:0] so;
  int         n_fail, comparisons;
  logic [5:0] rw_a [14] = '{6'h01, 6'h02, 6'h05, 6'h06, 6'h07, 6'h10,
    6'h11, 6'h13, 6'h14, 6'h20, 6'h22, 6'h24, 6'h26, 6'h27};
  logic [3:0] rw_m [14] = '{4'hF, 4'h3, 4'h3, 4'hF, 4'h3, 4'hF, 4'hF,
    4'h3, 4'hF, 4'hF, 4'hF, 4'h7, 4'h1, 4'h3};
  logic [5:0] fa [3] = '{ADDR_SYN_UNLK, ADDR_WDT_STAT, ADDR_BT_CARRY};
  ctl_nibble_bank dut_u (
    .i_mclk(clk), .i_arst_n(rst_n), .i_rf_addr(addr),
    .i_regfile_read_instr(rd), .i_regfile_write_instr(wr),
    .i_window_wdata(wdat), .o_window_rdata(rdat), .o_window_rvalid(rvld),
    .i_buffer_stack_pointer(bsp), .i_if_count_gate_open(gate),
    .i_adc_compare(cmp), .i_synth_unlock_event(ev[0]),
    .i_watchdog_stack_event(ev[1]), .i_base_timer_carry_event(ev[2]),
    .o_stack_pointer(spo), .o_watchdog_clock_select(so[1:0]),
    .o_stack_fault_reset_select(so[3:2]),
    .o_chip_enable_reset_counter(so[7:4]),
    .o_table_move_bit_select(so[9:8]), .o_synth_mode_select(so[13:10]),
    .o_synth_reference_select(so[17:14]),
    .o_tone_pin_function_select(so[19:18]),
    .o_tone_clock_select(so[23:20]), .o_freq_gate_channel(so[27:24]),
    .o_if_count_mode(ifm), .o_analog_sample_channel(so[30:28]),
    .o_analog_sample_mode(amode), .o_pulse_width_clock_select(so[31]),
    .o_pulse_width_pin_select(so[33:32]),
    .o_synth_unlock_flag(flg[0]), .o_watchdog_stack_flag(flg[1]),
    .o_base_timer_carry_flag(flg[2]), .o_watchdog_counter_clear(wclr),
    .o_if_count_start(ifs), .o_if_count_reset(ifr)
  );
  task automatic close_out;
    if (n_fail == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out
  // Idle edge first, so no strobe is set twice in one time step
  task automatic wr_nib(input logic [5:0] a, input logic [3:0] v);
    @(posedge clk); #2; addr = a; wdat = v; wr = 1'b1;
    @(posedge clk); #2; wr = 1'b0;
  endtask : wr_nib
  task automatic rd_nib(input logic [5:0] a);
    @(posedge clk); #2; addr = a; rd = 1'b1;
    @(posedge clk); #2; rd = 1'b0;
    `CHK("read valid", 1'b1, rvld)
  endtask : rd_nib
  task automatic t_rw;
    for (int i = 0; i < 14; i++) begin
      rd_nib(rw_a[i]);
      `CHK("untouched location", 4'h0, rdat)
      wr_nib(rw_a[i], rw_m[i]);
      rd_nib(rw_a[i]);
      `CHK("writable bits", rw_m[i], rdat)
    end
    `CHK("setting outputs", 34'h3FFFFFFFF, so)
    `CHK("stack pointer", 4'hF, spo)
    wr_nib(ADDR_IF_MODE, 4'h5);
    `CHK("counter mode", 4'h5, ifm)
  endtask : t_rw
  task automatic t_ro;
    bsp = 2'h2; gate = 1'b1; cmp = 1'b1;
    wr_nib(ADDR_BUF_SP, 4'h0);
    rd_nib(ADDR_BUF_SP);
    `CHK("buffer pointer", 4'h2, rdat)
    wr_nib(ADDR_IF_GATE, 4'h0);
    rd_nib(ADDR_IF_GATE);
    `CHK("gate status", 4'h1, rdat)
    wr_nib(ADDR_ADC_MODE, 4'h6);
    rd_nib(ADDR_ADC_MODE);
    `CHK("converter mode", 4'h7, rdat)
    `CHK("converter mode out", 2'h3, amode)
  endtask : t_ro
  task automatic t_rc;
    for (int i = 0; i < 3; i++) begin
      wr_nib(fa[i], 4'h1);
      `CHK("flag after write", 1'b0, flg[i])
      @(posedge clk); #2; ev[i] = 1'b1;
      @(posedge clk); #2; ev[i] = 1'b0;
      rd_nib(fa[i]);
      `CHK("flag read", 4'h1, rdat)
      `CHK("flag cleared", 1'b0, flg[i])
      rd_nib(fa[i]);
      `CHK("flag reread", 4'h0, rdat)
    end
    // Event in the clearing read's cycle must not be lost
    ev[0] = 1'b1;
    rd_nib(fa[0]);
    ev[0] = 1'b0;
    `CHK("flag kept by event", 1'b1, flg[0])
    rd_nib(fa[0]);
    `CHK("flag read after event", 4'h1, rdat)
  endtask : t_rc
  task automatic t_wo;
    wr_nib(ADDR_WDT_CLR, 4'h8);
    `CHK("watchdog clear", 1'b1, wclr)
    wr_nib(ADDR_IF_CTRL, 4'h3);
    `CHK("counter commands", 2'h3, {ifs, ifr})
    `CHK("watchdog clear end", 1'b0, wclr)
  endtask : t_wo
  task automatic t_unused;
    wr_nib(6'h15, 4'hF);
    wr_nib(6'h3F, 4'h0);
    `CHK("stack pointer kept", 4'hF, spo)
    `CHK("counter mode kept", 4'h5, ifm)
    `CHK("settings kept", 34'h3FFFFFFFF, so)
  endtask : t_unused
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #100000;
    n_fail++;
    close_out();
  end
  initial begin
    rst_n = 1'b0; rd = 1'b0; wr = 1'b0; addr = 6'h00; wdat = 4'h0;
    bsp = 2'h0; gate = 1'b0; cmp = 1'b0; ev = 3'h0;
    n_fail = 0; comparisons = 0;
    repeat (8) @(posedge clk);
    #2; rst_n = 1'b1;
    t_rw(); t_ro(); t_rc(); t_wo(); t_unused();
    close_out();
  end
endmodule : test_peripheral_control_nibble_bank
